/* asom_pkg.sv */
// asom_pkg: constants and types for the alignment and overrange monitor
// assumes: single clock domain, registers on a plain strobe port
package asom_pkg;
    // ==========================================================
    // register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h2;
    localparam logic [3:0] OFS_IRQ_EN = 4'h3;
    localparam logic [3:0] OFS_RESULT = 4'h4;
    localparam logic [3:0] OFS_REF_COUNT = 4'h5;
    // ==========================================================
    // control field positions
    localparam int CTL_ALIGN = 0;
    localparam int CTL_EXTERNAL_MASTER_CLOCK_SEL = 1;
    localparam int CTL_PIN0_EN = 2;
    localparam int CTL_PIN1_EN = 3;
    localparam int CTL_REG_EN = 4;
    localparam int CTL_CUR_EN = 5;
    localparam logic [5:0] CTRL_RESET = 6'h10;
    // ==========================================================
    // status and event bits
    localparam int ST_DOR = 0;
    localparam int ST_AOR = 1;
    localparam int EV_RESYNC = 0;
    localparam int EV_RESULT = 1;
    localparam int EV_DOR = 2;
    localparam int EV_AOR = 3;
    localparam int NUM_EV = 4;
    // ==========================================================
    // result codes
    localparam logic [23:0] CLAMP_POS = 24'h7fffff;
    localparam logic [23:0] CLAMP_NEG = 24'h800000;
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    localparam int COUNT_W = 20;
    localparam int SETTLE_CONV = 5;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
        logic dig_pos;
        logic dig_neg;
        logic ana_over;
    } asom_sample_t;

    typedef enum logic [1:0] {
        AL_IDLE = 2'b00,
        AL_WAIT_RDY = 2'b01,
        AL_COUNT = 2'b10
    } asom_align_t;
endpackage : asom_pkg

/* asom_monitor.sv */
// asom_monitor: holds no logic; the whole monitor lives in asom_top
// assumes: nothing; compiling this file adds no module


/* asom_top.sv */
// asom_top: alignment check, filter restart and overrange flags
// assumes: filter core delivers one sample struct per conversion; inputs
// synchronous to i_ref_clk
//
// Overview of operation
// - Count clocks from ready assertion to next pulse rise; store as reference.
// - Recount each pulse; off by more than one restarts conversion and filter.
// - Count within one of reference lets conversions continue untouched.
// - After restart, result valid strobe withheld for the full filter settling latency.
// - Pulses before the first ready falling edge after startup are ignored.
// - First pulse rise after ready assertion sets the reference timing.
// - Filter overflow sets digital flag and loads clamp code by polarity.
// - Analog flag asserts when input exceeds modulator limits, either polarity.
// - Analog flag is set only with or after the result register update.
// - Analog flag and result register always change together.
// - Bipolar results and clamp codes are two's complement.
// - Fifth-order sinc output from fourth-order modulator gives 24-bit results.
// - Sensor-test currents are on whenever the enable bit is set.
`timescale 1ns/10ps
module asom_top #(
    parameter int SETTLE = asom_pkg::SETTLE_CONV
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_align_pulse,
    input wire logic i_result_ready_n,
    input wire asom_pkg::asom_sample_t i_sample,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_filter_restart,
    output logic o_result_valid,
    output logic o_core_regulator_enable,
    output logic o_sensor_test_current_enable,
    output logic o_pin0_general_use_enable,
    output logic o_pin1_general_use_enable,
    output logic o_external_master_clock_sel
);
    localparam int CW = asom_pkg::COUNT_W;
    localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
    localparam logic [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
    localparam logic [7:0] SETTLE_N = 8'(SETTLE);

    // ==========================================================
    // state
    logic [5:0] ctrl_r, ctrl_nxt;
    logic [3:0] irq_en_r, irq_en_nxt;
    logic [3:0] irq_st_r, irq_st_nxt;
    logic [23:0] result_r, result_nxt;
    logic dor_r, dor_nxt;
    logic aor_r, aor_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic valid_r, valid_nxt;
    logic restart_r, restart_nxt;
    logic [7:0] settle_r, settle_nxt;
    asom_pkg::asom_align_t al_r, al_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [CW-1:0] ref_r, ref_nxt;
    logic have_ref_r, have_ref_nxt;
    logic armed_r, armed_nxt;
    logic rdy_d_r, rdy_d_nxt;
    logic pulse_d_r, pulse_d_nxt;
    logic [3:0] ev;

    function automatic logic within_one(input logic [CW-1:0] a, input logic [CW-1:0] b);
        logic [CW-1:0] d;
        // one cycle either way absorbs the jitter of a pulse edge against the clock
        d = (a > b) ? (a - b) : (b - a);
        return d <= CNT_ONE;
    endfunction : within_one

    wire rdy_fall = rdy_d_r & ~i_result_ready_n;
    wire pulse_rise = i_align_pulse & ~pulse_d_r;
    wire mode_on = ctrl_r[asom_pkg::CTL_ALIGN] & ctrl_r[asom_pkg::CTL_EXTERNAL_MASTER_CLOCK_SEL];
    wire pins_ok = ~ctrl_r[asom_pkg::CTL_PIN0_EN] & ~ctrl_r[asom_pkg::CTL_PIN1_EN];
    wire check_on = mode_on & pins_ok;

    // ==========================================================
    // pin edge detectors
    // reset high: a high pulse at release does not read as an edge, but a low ready does
    always_comb begin
        rdy_d_nxt = i_result_ready_n;
        pulse_d_nxt = i_align_pulse;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdy_d_r <= 1'b1;
            pulse_d_r <= 1'b1;
        end else begin
            rdy_d_r <= rdy_d_nxt;
            pulse_d_r <= pulse_d_nxt;
        end
    end

    // ==========================================================
    // alignment counter
    always_comb begin
        al_nxt = al_r;
        cnt_nxt = cnt_r;
        ref_nxt = ref_r;
        have_ref_nxt = have_ref_r;
        armed_nxt = armed_r | rdy_fall;
        restart_nxt = 1'b0;
        if (!check_on) begin
            // leaving the mode drops the reference; re-entry measures afresh
            al_nxt = asom_pkg::AL_IDLE;
            have_ref_nxt = 1'b0;
        end else begin
            case (al_r)
                asom_pkg::AL_IDLE: begin
                    if (rdy_fall) begin
                        // edge is seen one cycle after the assertion, so start at one
                        al_nxt = asom_pkg::AL_COUNT;
                        cnt_nxt = CNT_ONE;
                    end else if (armed_r) begin
                        al_nxt = asom_pkg::AL_WAIT_RDY;
                    end
                end
                asom_pkg::AL_WAIT_RDY: begin
                    // pulses seen here have no ready edge to measure from
                    if (rdy_fall) begin
                        al_nxt = asom_pkg::AL_COUNT;
                        cnt_nxt = CNT_ONE;
                    end
                end
                asom_pkg::AL_COUNT: begin
                    // saturates so a lost pulse cannot wrap into a false match
                    if (cnt_r != CNT_MAX) begin
                        cnt_nxt = cnt_r + CNT_ONE;
                    end
                    if (pulse_rise) begin
                        al_nxt = asom_pkg::AL_WAIT_RDY;
                        if (!have_ref_r) begin
                            ref_nxt = cnt_r;
                            have_ref_nxt = 1'b1;
                        end else if (!within_one(cnt_r, ref_r)) begin
                            restart_nxt = 1'b1;
                        end
                        // else conversions continue untouched
                    end else if (rdy_fall) begin
                        cnt_nxt = CNT_ONE;
                    end
                end
                default: al_nxt = asom_pkg::AL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            al_r <= asom_pkg::AL_IDLE;
            cnt_r <= '0;
            ref_r <= '0;
            have_ref_r <= 1'b0;
            armed_r <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            al_r <= al_nxt;
            cnt_r <= cnt_nxt;
            ref_r <= ref_nxt;
            have_ref_r <= have_ref_nxt;
            armed_r <= armed_nxt;
            restart_r <= restart_nxt;
        end
    end

    // ==========================================================
    // result path and flags
    always_comb begin
        result_nxt = result_r;
        dor_nxt = dor_r;
        aor_nxt = aor_r;
        settle_nxt = settle_r;
        valid_nxt = 1'b0;
        if (restart_r) begin
            settle_nxt = SETTLE_N;
        end else if (i_sample.valid) begin
            // result still updates while settling; only the valid strobe is withheld
            // result and analog flag update in the same edge
            if (i_sample.dig_pos) begin
                result_nxt = asom_pkg::CLAMP_POS;
            end else if (i_sample.dig_neg) begin
                result_nxt = asom_pkg::CLAMP_NEG;
            end else begin
                result_nxt = i_sample.data;
            end
            dor_nxt = i_sample.dig_pos | i_sample.dig_neg;
            aor_nxt = i_sample.ana_over | dor_nxt;
            if (settle_r != 8'h00) begin
                settle_nxt = settle_r - 8'h01;
            end else begin
                valid_nxt = 1'b1;
            end
        end
    end

    // ==========================================================
    // register port and interrupts
    // events come from registered state so they line up with the outputs
    always_comb begin
        ev = '0;
        ev[asom_pkg::EV_RESYNC] = restart_r;
        ev[asom_pkg::EV_RESULT] = valid_r;
        ev[asom_pkg::EV_DOR] = valid_r & dor_r;
        ev[asom_pkg::EV_AOR] = valid_r & aor_r;
        ctrl_nxt = ctrl_r;
        irq_en_nxt = irq_en_r;
        irq_st_nxt = irq_st_r;
        // unmapped writes fall through the default and change nothing
        if (i_wr) begin
            case (i_addr)
                asom_pkg::OFS_CTRL: ctrl_nxt = i_wdata[5:0];
                asom_pkg::OFS_IRQ_EN: irq_en_nxt = i_wdata[3:0];
                asom_pkg::OFS_IRQ_CLR: irq_st_nxt = irq_st_r & ~i_wdata[3:0];
                default: ;
            endcase
        end
        // a new event wins over a same-cycle clear
        irq_st_nxt = irq_st_nxt | ev;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= asom_pkg::CTRL_RESET;
            irq_en_r <= '0;
            irq_st_r <= '0;
            result_r <= asom_pkg::RESULT_RESET;
            dor_r <= 1'b0;
            aor_r <= 1'b0;
            valid_r <= 1'b0;
            settle_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            irq_en_r <= irq_en_nxt;
            irq_st_r <= irq_st_nxt;
            result_r <= result_nxt;
            dor_r <= dor_nxt;
            aor_r <= aor_nxt;
            valid_r <= valid_nxt;
            settle_r <= settle_nxt;
        end
    end

    // ==========================================================
    // read data: stands one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_nxt = '0;
        if (i_rd) begin
            case (i_addr)
                asom_pkg::OFS_CTRL: rdata_nxt = {26'h0000000, ctrl_r};
                asom_pkg::OFS_STATUS: rdata_nxt = {26'h0000000, irq_st_r, aor_r, dor_r};
                asom_pkg::OFS_IRQ_EN: rdata_nxt = {28'h0000000, irq_en_r};
                asom_pkg::OFS_RESULT: rdata_nxt = {8'h00, result_r};
                asom_pkg::OFS_REF_COUNT: rdata_nxt = {{(32-CW){1'b0}}, ref_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // interrupt level
    // built from next values so a new event raises the pin on its own edge
    always_comb begin
        irq_nxt = |(irq_st_nxt & irq_en_nxt);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;
    assign o_filter_restart = restart_r;
    assign o_result_valid = valid_r;
    assign o_core_regulator_enable = ctrl_r[asom_pkg::CTL_REG_EN];
    assign o_sensor_test_current_enable = ctrl_r[asom_pkg::CTL_CUR_EN];
    assign o_pin0_general_use_enable = ctrl_r[asom_pkg::CTL_PIN0_EN];
    assign o_pin1_general_use_enable = ctrl_r[asom_pkg::CTL_PIN1_EN];
    assign o_external_master_clock_sel = ctrl_r[asom_pkg::CTL_EXTERNAL_MASTER_CLOCK_SEL];
endmodule : asom_top

/* asom_asserts.sv */
// asom_asserts: port-level checks for the alignment and overrange monitor
// assumes: bound to asom_top, one clock domain, async active-low reset
`timescale 1ns/10ps
module asom_asserts #(
    parameter int SETTLE = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_align_pulse,
    input wire logic i_result_ready_n,
    input wire asom_pkg::asom_sample_t i_sample,
    input wire logic [31:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_filter_restart,
    input wire logic o_result_valid,
    input wire logic o_core_regulator_enable,
    input wire logic o_sensor_test_current_enable,
    input wire logic o_pin0_general_use_enable,
    input wire logic o_pin1_general_use_enable,
    input wire logic o_external_master_clock_sel
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [7:0] smp_cnt_r;
    logic [7:0] smp_cnt_nxt;
    // ==========================================================
    // samples since last restart; starts saturated so reset needs no settling
    always_comb begin
        smp_cnt_nxt = smp_cnt_r + {7'h00, i_sample.valid && smp_cnt_r != 8'hff};
        if (o_filter_restart) begin
            smp_cnt_nxt = 8'h00;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            smp_cnt_r <= 8'hff;
        end else begin
            smp_cnt_r <= smp_cnt_nxt;
        end
    end
    // ==========================================================
    // assertions
    chk_restart_cause: assert property (o_filter_restart |->
        $past(i_align_pulse) && !$past(i_align_pulse, 2)) else $error("restart without pulse");
    chk_restart_single: assert property (o_filter_restart |=>
        !o_filter_restart) else $error("restart longer than one cycle");
    chk_restart_mode: assert property (o_filter_restart |->
        $past(o_external_master_clock_sel) && !$past(o_pin0_general_use_enable)
        && !$past(o_pin1_general_use_enable)) else $error("restart outside check mode");
    chk_settle_gap: assert property (o_result_valid |->
        smp_cnt_r > SETTLE) else $error("result valid during settling");
    chk_valid_cause: assert property (o_result_valid |->
        $past(i_sample.valid)) else $error("result valid without sample");
    chk_ctrl_cur: assert property (i_wr && i_addr == asom_pkg::OFS_CTRL |=>
        o_sensor_test_current_enable == $past(i_wdata[5])) else $error("test current bit");
    chk_ctrl_pins: assert property (i_wr && i_addr == asom_pkg::OFS_CTRL |=>
        {o_pin1_general_use_enable, o_pin0_general_use_enable, o_external_master_clock_sel}
        == $past(i_wdata[3:1])) else $error("pin or clock select bits");
    chk_ctrl_hold: assert property (!$past(i_wr) |->
        $stable(o_sensor_test_current_enable) && $stable(o_core_regulator_enable))
        else $error("control output moved without write");
    cover property (o_filter_restart);
    cover property (o_result_valid);
    cover property (o_irq);
endmodule : asom_asserts

/* asom_sync_src.sv */
// asom_sync_src: far-side event source, ready edge then alignment pulse
// assumes: commanded by the bench one event at a time via i_go
`timescale 1ns/10ps
module asom_sync_src (
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic i_skip_ready,
    input wire logic [7:0] i_gap,
    output logic o_ready_n,
    output logic o_pulse,
    output logic o_busy
);
    initial begin
        o_ready_n = 1'b1;
        o_pulse = 1'b0;
        o_busy = 1'b0;
    end
    // ready falls at the go edge, pulse rises i_gap edges later
    always @(posedge i_ref_clk) begin
        if (i_go) begin
            o_busy <= 1'b1;
            o_ready_n <= i_skip_ready;
            @(posedge i_ref_clk) o_ready_n <= 1'b1;
            repeat (int'(i_gap) - 1) @(posedge i_ref_clk);
            o_pulse <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_pulse <= 1'b0;
            o_busy <= 1'b0;
        end
    end
endmodule : asom_sync_src

/* testbench.sv */
// testbench: drives the monitor, models results and alignment outcomes
// assumes: asom_pkg, asom_top, asom_asserts, asom_sync_src compiled first
`timescale 1ns/10ps
module testbench;
    localparam int SETTLE = 3;
    logic clk, rst_n, wr, rd, go, skip, busy, rdy_n, pulse;
    logic irq, restart, res_valid, reg_en, cur_en, pin0, pin1, ext;
    logic [3:0] addr;
    logic [7:0] gap;
    logic [5:0] ctl;
    logic [31:0] wdata, rdata, rv;
    asom_pkg::asom_sample_t smp;
    int fails, compares, settle_left;
    int gaps[$] = '{20, 20, 21, 19, 22};
    int rsts[$] = '{0, 0, 0, 0, 1};
    asom_top #(.SETTLE(SETTLE)) dut_u (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_align_pulse(pulse),
        .i_result_ready_n(rdy_n), .i_sample(smp), .o_rdata(rdata), .o_irq(irq),
        .o_filter_restart(restart), .o_result_valid(res_valid),
        .o_core_regulator_enable(reg_en), .o_sensor_test_current_enable(cur_en),
        .o_pin0_general_use_enable(pin0), .o_pin1_general_use_enable(pin1),
        .o_external_master_clock_sel(ext));
    asom_sync_src src_u (.i_ref_clk(clk), .i_go(go), .i_skip_ready(skip), .i_gap(gap),
        .o_ready_n(rdy_n), .o_pulse(pulse), .o_busy(busy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // one conversion through the bench model; clamps win over raw data
    task automatic conv(input logic [23:0] d, input logic p, input logic n, input logic a);
        logic [23:0] er;
        er = p ? asom_pkg::CLAMP_POS : (n ? asom_pkg::CLAMP_NEG : d);
        @(posedge clk);
        smp <= '{1'b1, d, p, n, a};
        @(posedge clk);
        smp.valid <= 1'b0;
        #1;
        chk(res_valid, settle_left == 0, "result valid");
        if (settle_left > 0) settle_left--;
        rd_reg(asom_pkg::OFS_RESULT, rv);
        chk(rv, {8'h00, er}, "result");
        rd_reg(asom_pkg::OFS_STATUS, rv);
        chk(rv[1:0], {a | p | n, p | n}, "flags");
    endtask : conv
    task automatic align(input logic s, input logic [7:0] g, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        go <= 1'b1;
        skip <= s;
        gap <= g;
        @(posedge clk);
        go <= 1'b0;
        // busy only shows once the model's update at this edge has landed
        #1;
        for (int j = 0; j < 300 && busy; j++) begin
            @(posedge clk);
            #1;
            seen = seen | restart;
        end
        if (busy) begin
            fails++;
            wrap_up();
        end else begin
            chk(seen, exp, "restart");
        end
    endtask : align
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_n, wr, rd, go, skip, addr, gap, wdata, fails, compares, settle_left} = '0;
        smp = '0;
        void'($urandom(91065));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(asom_pkg::OFS_CTRL, rv);
        chk(rv, {26'h0, asom_pkg::CTRL_RESET}, "ctrl reset");
        rd_reg(4'hf, rv);
        chk(rv, 32'h0, "unmapped read");
        repeat (8) begin
            ctl = 6'($urandom);
            wr_reg(asom_pkg::OFS_CTRL, {26'h0, ctl});
            chk({cur_en, reg_en, pin1, pin0, ext}, ctl[5:1], "ctrl outputs");
        end
        wr_reg(asom_pkg::OFS_CTRL, 32'h10);
        repeat (6) conv(24'($urandom), 1'b0, 1'b0, 1'b0);
        conv(24'h000123, 1'b1, 1'b0, 1'b1);
        conv(24'h000042, 1'b0, 1'b0, 1'b0);
        conv(24'hfff000, 1'b0, 1'b1, 1'b1);
        conv(24'h7ffff0, 1'b0, 1'b0, 1'b1);
        conv(24'h000001, 1'b0, 1'b0, 1'b0);
        wr_reg(asom_pkg::OFS_IRQ_CLR, 32'hf);
        wr_reg(asom_pkg::OFS_IRQ_EN, 32'h4);
        rd_reg(asom_pkg::OFS_IRQ_EN, rv);
        chk(rv, 32'h4, "irq enable readback");
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0, "irq idle");
        conv(24'h0, 1'b1, 1'b0, 1'b1);
        chk(irq, 1'b1, "irq raised");
        wr_reg(asom_pkg::OFS_IRQ_CLR, 32'h4);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0, "irq cleared");
        wr_reg(asom_pkg::OFS_IRQ_EN, 32'h0);
        conv(24'h0, 1'b0, 1'b1, 1'b1);
        chk(irq, 1'b0, "irq masked");
        wr_reg(asom_pkg::OFS_CTRL, 32'h13);
        align(1'b1, 8'd20, 1'b0);
        foreach (gaps[i]) align(1'b0, 8'(gaps[i]), rsts[i][0]);
        rd_reg(asom_pkg::OFS_REF_COUNT, rv);
        chk(rv, 32'(gaps[0]), "reference count");
        rd_reg(asom_pkg::OFS_STATUS, rv);
        chk(rv[asom_pkg::EV_RESYNC + 2], 1'b1, "resync event");
        settle_left = SETTLE;
        repeat (SETTLE + 1) conv(24'($urandom), 1'b0, 1'b0, 1'b0);
        wr_reg(asom_pkg::OFS_CTRL, 32'h17);
        align(1'b0, 8'd10, 1'b0);
        align(1'b0, 8'd40, 1'b0);
        wrap_up();
    end
endmodule : testbench
bind asom_top asom_asserts #(.SETTLE(SETTLE)) chk_u (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_align_pulse(i_align_pulse), .i_result_ready_n(i_result_ready_n),
    .i_sample(i_sample), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_filter_restart(o_filter_restart), .o_result_valid(o_result_valid),
    .o_core_regulator_enable(o_core_regulator_enable),
    .o_sensor_test_current_enable(o_sensor_test_current_enable),
    .o_pin0_general_use_enable(o_pin0_general_use_enable),
    .o_pin1_general_use_enable(o_pin1_general_use_enable),
    .o_external_master_clock_sel(o_external_master_clock_sel));
